// >>> logic/psu_top.sv
// Purpose: port select unit, strobes, requests, status arbitration
// Assumes: processor holds address and op bits stable during an op
// Notes:   AXI4-Lite slave holds an interrupt port mask and a status view
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module psiu_top (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic      [1:0]  bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [2:0]  extOpBits,
  input  wire logic        baseRegChoiceBit,
  input  wire logic        upperGroupSelN,
  input  wire logic        addrBitMid,
  input  wire logic        addrBitLow,
  input  wire logic        instructionFlagLine,
  input  wire logic        addrStatusStrobeN,
  input  wire logic [7:0]  dataInterruptN,
  input  wire logic [7:0]  statusInterruptN,
  output logic      [7:0]  readStrobeN,
  output logic      [7:0]  writeStrobeN,
  output logic             instrFlagToIoc,
  output logic             solicitedRequestOutN,
  output logic             unsolicitedRequestOutN,
  output logic             generalRequestOutN,
  output logic             lowerGroupDisableN,
  output logic      [7:0]  statusEnableN,
  output logic      [2:0]  winningPortAddrLinesN,
  output logic             winningPortAddrOe
);
  // bus group state
  logic        awHeldReg,  awHeldNext;
  logic [7:0]  awAddrReg,  awAddrNext;
  logic        wHeldReg,   wHeldNext;
  logic [31:0] wDataReg,   wDataNext;
  logic [3:0]  wStrbReg,   wStrbNext;
  logic        bvalidReg,  bvalidNext;
  logic [1:0]  brespReg,   brespNext;
  logic        rvalidReg,  rvalidNext;
  logic [31:0] rdataReg,   rdataNext;
  logic [1:0]  rrespReg,   rrespNext;
  logic [7:0]  ctrlReg,    ctrlNext;
  // port group state
  logic [7:0]  writeSelReg,   writeSelNext;
  logic [7:0]  readPulseReg,  readPulseNext;
  logic        instrFlagReg,  instrFlagNext;
  logic        lastBaseReg,   lastBaseNext;
  logic [7:0]  statusEnReg,   statusEnNext;
  logic [2:0]  addrLinesReg,  addrLinesNext;
  logic        addrOeReg,     addrOeNext;
  logic [2:0]  lastWinReg,    lastWinNext;
  // decode and arbitration
  logic        opRead;
  logic        opWrite;
  logic [2:0]  devAddr;
  logic [7:0]  dataEff;
  logic [7:0]  statEff;
  logic [7:0]  intReqEff;
  logic [7:0]  readHit;
  logic [7:0]  writeHit;
  logic        loAny;
  logic        hiAny;
  logic        loWin;
  logic        hiWin;
  logic [1:0]  loIdx;
  logic [1:0]  hiIdx;
  logic [2:0]  winAddr;
  logic        winValid;
  logic [31:0] statusWord;

  assign opRead    = (extOpBits == psiu_pkg::OP_DEV_READ);
  assign opWrite   = (extOpBits == psiu_pkg::OP_DEV_WRITE);
  // address is only meaningful while an op is decoded
  assign devAddr   = {~upperGroupSelN, addrBitMid, addrBitLow};
  assign dataEff   = ~dataInterruptN & ctrlReg;
  assign statEff   = ~statusInterruptN & ctrlReg;
  assign intReqEff = dataEff | statEff;

  psiu_port_selector lowerHalf (
    .slotUpper      (1'b0),
    .upperGroupSelN (upperGroupSelN),
    .portIdx        (devAddr[1:0]),
    .opRead         (opRead),
    .opWrite        (opWrite),
    .intReq         (intReqEff[3:0]),
    .outEnableN     (~lowerGroupDisableN),
    .readHit        (readHit[3:0]),
    .writeHit       (writeHit[3:0]),
    .anyReq         (loAny),
    .winValid       (loWin),
    .winIdx         (loIdx)
  );

  psiu_port_selector upperHalf (
    .slotUpper      (1'b1),
    .upperGroupSelN (upperGroupSelN),
    .portIdx        (devAddr[1:0]),
    .opRead         (opRead),
    .opWrite        (opWrite),
    .intReq         (intReqEff[7:4]),
    .outEnableN     (1'b0),
    .readHit        (readHit[7:4]),
    .writeHit       (writeHit[7:4]),
    .anyReq         (hiAny),
    .winValid       (hiWin),
    .winIdx         (hiIdx)
  );

  assign lowerGroupDisableN = ~hiAny;
  assign winAddr  = hiWin ? {1'b1, hiIdx} : {1'b0, loIdx};
  assign winValid = hiWin | loWin;

  // request outputs stay combinational so they track the interrupt level
  assign solicitedRequestOutN   = ~|(writeSelReg & dataEff);
  assign unsolicitedRequestOutN = ~|(writeSelReg & statEff);
  assign generalRequestOutN     = ~|(~writeSelReg & intReqEff);

  assign readStrobeN           = ~readPulseReg;
  assign writeStrobeN          = ~writeSelReg;
  assign instrFlagToIoc        = instrFlagReg;
  assign statusEnableN         = ~statusEnReg;
  assign winningPortAddrLinesN = ~addrLinesReg;
  assign winningPortAddrOe     = addrOeReg;

  always_comb
  begin
    writeSelNext  = writeSelReg;
    readPulseNext = readHit;
    instrFlagNext = instrFlagReg;
    lastBaseNext  = lastBaseReg;
    lastWinNext   = lastWinReg;
    if (opWrite)
      writeSelNext = writeHit;
    if (opRead || opWrite)
    begin
      instrFlagNext = instructionFlagLine;
      lastBaseNext  = baseRegChoiceBit;
    end
    statusEnNext  = 8'h00;
    addrLinesNext = 3'h0;
    addrOeNext    = 1'b0;
    // one enable at most, so a single control drives the input bus
    if (!addrStatusStrobeN && winValid)
    begin
      statusEnNext  = psiu_pkg::psiu_decode8(winAddr);
      addrLinesNext = winAddr;
      addrOeNext    = 1'b1;
      lastWinNext   = winAddr;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      writeSelReg  <= 8'h00;
      readPulseReg <= 8'h00;
      instrFlagReg <= 1'b0;
      lastBaseReg  <= 1'b0;
      statusEnReg  <= 8'h00;
      addrLinesReg <= 3'h0;
      addrOeReg    <= 1'b0;
      lastWinReg   <= 3'h0;
    end
    else
    begin
      writeSelReg  <= writeSelNext;
      readPulseReg <= readPulseNext;
      instrFlagReg <= instrFlagNext;
      lastBaseReg  <= lastBaseNext;
      statusEnReg  <= statusEnNext;
      addrLinesReg <= addrLinesNext;
      addrOeReg    <= addrOeNext;
      lastWinReg   <= lastWinNext;
    end
  end

  // register slave
  assign awready = !awHeldReg && !bvalidReg;
  assign wready  = !wHeldReg && !bvalidReg;
  assign arready = !rvalidReg;
  assign bvalid  = bvalidReg;
  assign bresp   = brespReg;
  assign rvalid  = rvalidReg;
  assign rdata   = rdataReg;
  assign rresp   = rrespReg;

  always_comb
  begin
    statusWord = 32'h0000_0000;
    statusWord[psiu_pkg::STAT_SEL_POS +: 8]  = writeSelReg;
    statusWord[psiu_pkg::STAT_PEND_POS +: 8] = ~(dataInterruptN & statusInterruptN);
    statusWord[psiu_pkg::STAT_WIN_POS +: 3]  = lastWinReg;
    statusWord[psiu_pkg::STAT_FLAG_POS]      = instrFlagReg;
    statusWord[psiu_pkg::STAT_BASE_POS]      = lastBaseReg;
  end

  always_comb
  begin
    awHeldNext = awHeldReg;
    awAddrNext = awAddrReg;
    wHeldNext  = wHeldReg;
    wDataNext  = wDataReg;
    wStrbNext  = wStrbReg;
    bvalidNext = bvalidReg;
    brespNext  = brespReg;
    rvalidNext = rvalidReg;
    rdataNext  = rdataReg;
    rrespNext  = rrespReg;
    ctrlNext   = ctrlReg;
    if (awvalid && awready)
    begin
      awHeldNext = 1'b1;
      awAddrNext = awaddr;
    end
    if (wvalid && wready)
    begin
      wHeldNext = 1'b1;
      wDataNext = wdata;
      wStrbNext = wstrb;
    end
    if (awHeldReg && wHeldReg && !bvalidReg)
    begin
      awHeldNext = 1'b0;
      wHeldNext  = 1'b0;
      bvalidNext = 1'b1;
      brespNext  = psiu_pkg::RESP_OKAY;
      if (awAddrReg == psiu_pkg::REG_CTRL_OFS)
      begin
        if (wStrbReg[0])
          ctrlNext = wDataReg[7:0];
      end
      else if (awAddrReg != psiu_pkg::REG_STAT_OFS)
        brespNext = psiu_pkg::RESP_DECERR;
    end
    if (bvalidReg && bready)
      bvalidNext = 1'b0;
    if (rvalidReg && rready)
      rvalidNext = 1'b0;
    if (arvalid && arready)
    begin
      rvalidNext = 1'b1;
      rrespNext  = psiu_pkg::RESP_OKAY;
      if (araddr == psiu_pkg::REG_CTRL_OFS)
        rdataNext = {24'h00_0000, ctrlReg};
      else if (araddr == psiu_pkg::REG_STAT_OFS)
        rdataNext = statusWord;
      else
      begin
        rdataNext = 32'h0000_0000;
        rrespNext = psiu_pkg::RESP_DECERR;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      awHeldReg <= 1'b0;
      awAddrReg <= 8'h00;
      wHeldReg  <= 1'b0;
      wDataReg  <= 32'h0000_0000;
      wStrbReg  <= 4'h0;
      bvalidReg <= 1'b0;
      brespReg  <= 2'h0;
      rvalidReg <= 1'b0;
      rdataReg  <= 32'h0000_0000;
      rrespReg  <= 2'h0;
      ctrlReg   <= psiu_pkg::CTRL_RESET;
    end
    else
    begin
      awHeldReg <= awHeldNext;
      awAddrReg <= awAddrNext;
      wHeldReg  <= wHeldNext;
      wDataReg  <= wDataNext;
      wStrbReg  <= wStrbNext;
      bvalidReg <= bvalidNext;
      brespReg  <= brespNext;
      rvalidReg <= rvalidNext;
      rdataReg  <= rdataNext;
      rrespReg  <= rrespNext;
      ctrlReg   <= ctrlNext;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  sequence statReqConsole;
    !addrStatusStrobeN && intReqEff[7];
  endsequence

  sequence consoleOnBus;
    !statusEnableN[7] && winningPortAddrOe && winningPortAddrLinesN == ~psiu_pkg::CONSOLE_ADDR;
  endsequence

  AST_PORT_MAP: assert property (opWrite |=> writeStrobeN == ~psiu_pkg::psiu_decode8($past(devAddr)))
    else $error("write strobe does not match address plus one");
  AST_ONE_STROBE: assert property ($onehot0(~readStrobeN) && $onehot0(~writeStrobeN))
    else $error("more than one port strobe active");
  AST_UPPER_HALF: assert property ((opRead && !upperGroupSelN) |=> readStrobeN[3:0] == 4'hf)
    else $error("lower half strobed while upper half chosen");
  AST_FLAG: assert property ((opRead || opWrite) |=> instrFlagToIoc == $past(instructionFlagLine))
    else $error("instruction flag not carried with address");
  AST_SOLICITED: assert property ((|(~writeStrobeN & dataEff)) |-> !solicitedRequestOutN)
    else $error("selected data interrupt gave no solicited request");
  AST_UNSOLICITED: assert property ((|(~writeStrobeN & statEff)) |-> !unsolicitedRequestOutN)
    else $error("selected status interrupt gave no unsolicited request");
  AST_GENERAL: assert property ((|(writeStrobeN & intReqEff)) |-> !generalRequestOutN)
    else $error("unselected interrupt gave no general request");
  AST_LOWER_OFF: assert property (hiAny |=> statusEnableN[3:0] == 4'hf)
    else $error("lower half enabled while upper group requests");
  AST_STAT_CONSOLE: assert property (statReqConsole |=> consoleOnBus)
    else $error("console did not win address and status transfer");
  AST_SINGLE_DRIVER: assert property ($onehot0(~statusEnableN))
    else $error("more than one status enable active");
  AST_BRESP: assert property ((awHeldReg && wHeldReg && !bvalidReg) |=> bvalid)
    else $error("write response missing");
endmodule : psiu_top
`default_nettype wire

// >>> inc/psu_pkg.sv
// What this block does
// - address zero to seven selects port one to eight
// - two identical halves serve ports 1-4, 5-8
// - low upper select picks upper half
// - console at port eight uses address seven
// - each operation asserts exactly one active-low strobe
// - instruction flag travels with address, marks control word
// - read with flag low moves a data word
// - read with flag set returns the status word
// - write strobe marks port selected, gates its interrupts
// - selected data interrupt drives solicited request low
// - selected status interrupt drives unsolicited request
// - unselected port interrupts drive the general request
// - address-status answer carries only highest-priority port
// - upper group request disables lower half output
// - winner plus address-status strobe enables its status
// - winner address drives bus lines with status bits
// - eight ports, console port eight highest priority
// - only one I/O control drives input bus
// Purpose: constants and helpers for the port select unit
// Assumes: one clock, inputs synchronous to it
// Notes:   register offsets are byte addresses on the AXI4-Lite slave
`default_nettype none
package psiu_pkg;
  localparam int          NUM_PORTS     = 8;
  localparam int          ADDR_W        = 8;
  localparam logic [2:0]  OP_DEV_READ   = 3'h1;
  localparam logic [2:0]  OP_DEV_WRITE  = 3'h2;
  localparam logic [2:0]  CONSOLE_ADDR  = 3'h7;
  localparam logic [7:0]  REG_CTRL_OFS  = 8'h00;
  localparam logic [7:0]  REG_STAT_OFS  = 8'h04;
  localparam logic [7:0]  CTRL_RESET    = 8'hff;
  localparam int          STAT_SEL_POS  = 0;
  localparam int          STAT_PEND_POS = 8;
  localparam int          STAT_WIN_POS  = 16;
  localparam int          STAT_FLAG_POS = 19;
  localparam int          STAT_BASE_POS = 20;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_DECERR   = 2'h3;

  function automatic logic [7:0] psiu_decode8(input logic [2:0] idx);
    psiu_decode8 = 8'h01 << idx;
  endfunction : psiu_decode8

  function automatic logic [3:0] psiu_decode4(input logic [1:0] idx);
    psiu_decode4 = 4'h1 << idx;
  endfunction : psiu_decode4

  // highest index wins
  function automatic logic [1:0] psiu_prio4(input logic [3:0] req);
    if (req[3])
      psiu_prio4 = 2'h3;
    else if (req[2])
      psiu_prio4 = 2'h2;
    else if (req[1])
      psiu_prio4 = 2'h1;
    else
      psiu_prio4 = 2'h0;
  endfunction : psiu_prio4
endpackage : psiu_pkg
`default_nettype wire

// >>> logic/psu_port_selector.sv
// Purpose: one selector half, four ports, decode and arbitration
// Assumes: slot position strapped, inputs synchronous
// Notes:   purely combinational; the top registers hits and winner, but anyReq leaves unregistered
`timescale 1ns/1ns
`default_nettype none
module psiu_port_selector (
  input  wire logic       slotUpper,
  input  wire logic       upperGroupSelN,
  input  wire logic [1:0] portIdx,
  input  wire logic       opRead,
  input  wire logic       opWrite,
  input  wire logic [3:0] intReq,
  input  wire logic       outEnableN,
  output logic      [3:0] readHit,
  output logic      [3:0] writeHit,
  output logic            anyReq,
  output logic            winValid,
  output logic      [1:0] winIdx
);
  logic halfHit;

  always_comb
  begin
    halfHit  = (upperGroupSelN != slotUpper);
    readHit  = (opRead && halfHit) ? psiu_pkg::psiu_decode4(portIdx) : 4'h0;
    writeHit = (opWrite && halfHit) ? psiu_pkg::psiu_decode4(portIdx) : 4'h0;
    anyReq   = |intReq;
    winValid = anyReq && !outEnableN;
    winIdx   = psiu_pkg::psiu_prio4(intReq);
  end
endmodule : psiu_port_selector
`default_nettype wire

// >>> sim/psu_ioc_model.sv
// Purpose: eight peripheral I/O controls facing the port select unit
// Assumes: key and status events arrive as one-cycle pulses from the bench
// Notes:   pending flags are levels; only a device read drops a data interrupt
`timescale 1ns/1ns
`default_nettype none
module psiu_ioc_model (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic [7:0] readStrobeN,
  input  wire logic [7:0] keyHit,
  input  wire logic [7:0] statHit,
  input  wire logic [7:0] statClr,
  output logic      [7:0] dataInterruptN,
  output logic      [7:0] statusInterruptN
);
  logic [7:0] dataPend_reg;
  logic [7:0] dataPend_next;
  logic [7:0] statPend_reg;
  logic [7:0] statPend_next;

  always_comb
  begin
    // device read fetches the word and drops the interrupt
    dataPend_next = (dataPend_reg & readStrobeN) | keyHit;
    // new key over an unread code is an overrun; ready button comes as statHit
    statPend_next = (statPend_reg | statHit | (keyHit & dataPend_reg)) & ~statClr;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dataPend_reg <= 8'h00;
      statPend_reg <= 8'h00;
    end
    else
    begin
      dataPend_reg <= dataPend_next;
      statPend_reg <= statPend_next;
    end
  end

  assign dataInterruptN   = ~dataPend_reg;
  assign statusInterruptN = ~statPend_reg;
endmodule : psiu_ioc_model
`default_nettype wire

// >>> sim/psu_top_tb.sv
// Purpose: self-checking bench for the port select unit
// Assumes: inputs change on the rising edge, outputs sampled on the falling edge
// Notes:   the model drops data interrupts only on a read strobe
`timescale 1ns/1ns
`default_nettype none
module psiu_top_tb;
  logic        clock, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, baseRegChoiceBit, upperGroupSelN;
  logic        addrBitMid, addrBitLow, instructionFlagLine, addrStatusStrobeN;
  logic        instrFlagToIoc, solicitedRequestOutN, unsolicitedRequestOutN;
  logic        generalRequestOutN, lowerGroupDisableN, winningPortAddrOe;
  logic [7:0]  awaddr, araddr, keyHit, statHit, statClr, dataInterruptN, statusInterruptN;
  logic [7:0]  readStrobeN, writeStrobeN, statusEnableN;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [2:0]  extOpBits, winningPortAddrLinesN;
  logic [1:0]  bresp, rresp, rs;
  int          nFail, samplesChecked;

  psiu_top dut_u (
    .clock, .rst_b, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .extOpBits, .baseRegChoiceBit, .upperGroupSelN, .addrBitMid,
    .addrBitLow, .instructionFlagLine, .addrStatusStrobeN, .dataInterruptN,
    .statusInterruptN, .readStrobeN, .writeStrobeN, .instrFlagToIoc, .solicitedRequestOutN,
    .unsolicitedRequestOutN, .generalRequestOutN, .lowerGroupDisableN, .statusEnableN,
    .winningPortAddrLinesN, .winningPortAddrOe
  );

  psiu_ioc_model ioc_u (
    .clock, .rst_b, .readStrobeN, .keyHit, .statHit, .statClr, .dataInterruptN,
    .statusInterruptN
  );

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      nFail++;
    end
  endtask : chk

  task wrapUp();
    $display("checks %0d mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrapUp

  // address and data offered together, each released once taken
  task axiWrite(input logic [7:0] adr, input logic [31:0] dat, input logic [1:0] exp);
    logic a, w, b;
    a = 1'b1;
    w = 1'b1;
    b = 1'b0;
    @(posedge clock);
    awaddr  <= adr;
    wdata   <= dat;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (a || w)
    begin
      @(negedge clock);
      b = awready;
      rs[0] = wready;
      @(posedge clock);
      if (a && b)
      begin
        awvalid <= 1'b0;
        a = 1'b0;
      end
      if (w && rs[0])
      begin
        wvalid <= 1'b0;
        w = 1'b0;
      end
    end
    bready <= 1'b1;
    do
    begin
      @(negedge clock);
      b  = bvalid;
      rs = bresp;
      @(posedge clock);
    end while (!b);
    bready <= 1'b0;
    chk("bresp", exp, rs);
  endtask : axiWrite

  task axiRead(input logic [7:0] adr);
    logic g;
    @(posedge clock);
    araddr  <= adr;
    arvalid <= 1'b1;
    do
    begin
      @(negedge clock);
      g = arready;
      @(posedge clock);
    end while (!g);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do
    begin
      @(negedge clock);
      g  = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge clock);
    end while (!g);
    rready <= 1'b0;
  endtask : axiRead

  // address lines presented with the op code and left standing after it drops
  task doOp(input logic [2:0] code, input logic [2:0] adr, input logic flag);
    @(posedge clock);
    extOpBits           <= code;
    upperGroupSelN      <= ~adr[2];
    addrBitMid          <= adr[1];
    addrBitLow          <= adr[0];
    instructionFlagLine <= flag;
    baseRegChoiceBit    <= adr[0];
    @(posedge clock);
    extOpBits <= 3'h0;
    @(negedge clock);
  endtask : doOp

  task kick(input logic [7:0] k, input logic [7:0] s, input logic [7:0] c);
    @(posedge clock);
    keyHit  <= k;
    statHit <= s;
    statClr <= c;
    @(posedge clock);
    keyHit  <= 8'h00;
    statHit <= 8'h00;
    statClr <= 8'h00;
    @(negedge clock);
  endtask : kick

  task addrStatReq(input logic [7:0] expEn, input logic [2:0] expAdr);
    @(posedge clock);
    addrStatusStrobeN <= 1'b0;
    @(posedge clock);
    addrStatusStrobeN <= 1'b1;
    @(negedge clock);
    chk("statusEnableN", expEn, statusEnableN);
    chk("winningPortAddrLinesN", expAdr, winningPortAddrLinesN);
    chk("winningPortAddrOe", 1'b1, winningPortAddrOe);
    @(negedge clock);
    chk("statusEnableN idle", 8'hff, statusEnableN);
    chk("winningPortAddrOe idle", 1'b0, winningPortAddrOe);
  endtask : addrStatReq

  initial
  begin
    #2_000_000;
    nFail++;
    wrapUp();
  end

  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0000000000000f;
    {keyHit, statHit, statClr, extOpBits} = 27'h0000000;
    {baseRegChoiceBit, upperGroupSelN, addrBitMid, addrBitLow} = 4'h4;
    instructionFlagLine = 1'b0;
    addrStatusStrobeN   = 1'b1;
    nFail               = 0;
    samplesChecked      = 0;
    rst_b               = 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    @(negedge clock);
    chk("writeStrobeN reset", 8'hff, writeStrobeN);
    chk("statusEnableN reset", 8'hff, statusEnableN);
    axiRead(psiu_pkg::REG_CTRL_OFS);
    chk("ctrl reset", 32'h000000ff, rd);
    axiRead(8'h40);
    chk("rresp unmapped", psiu_pkg::RESP_DECERR, rs);
    axiWrite(8'h40, 32'h0, psiu_pkg::RESP_DECERR);
    for (int a = 0; a < 8; a++)
    begin
      doOp(psiu_pkg::OP_DEV_WRITE, 3'(a), a[0]);
      chk("writeStrobeN", 8'(~(8'h01 << a)), writeStrobeN);
      chk("instrFlagToIoc", a[0], instrFlagToIoc);
      doOp(psiu_pkg::OP_DEV_READ, 3'(a), !a[0]);
      chk("readStrobeN", 8'(~(8'h01 << a)), readStrobeN);
      chk("instrFlagToIoc rd", !a[0], instrFlagToIoc);
      @(negedge clock);
      chk("readStrobeN idle", 8'hff, readStrobeN);
    end
    kick(8'h80, 8'h00, 8'h00);
    chk("solicitedRequestOutN", 1'b0, solicitedRequestOutN);
    chk("generalRequestOutN", 1'b1, generalRequestOutN);
    kick(8'h80, 8'h00, 8'h00);
    chk("unsolicitedRequestOutN", 1'b0, unsolicitedRequestOutN);
    doOp(psiu_pkg::OP_DEV_READ, 3'h7, 1'b0);
    @(negedge clock);
    chk("solicited cleared", 1'b1, solicitedRequestOutN);
    kick(8'h04, 8'h00, 8'h00);
    chk("generalRequestOutN", 1'b0, generalRequestOutN);
    chk("lowerGroupDisableN", 1'b0, lowerGroupDisableN);
    addrStatReq(8'h7f, 3'h0);
    axiRead(psiu_pkg::REG_STAT_OFS);
    chk("status selected", 32'h00000080, {24'h0, rd[7:0]});
    chk("status winner", 32'h00000007, {29'h0, rd[18:16]});
    chk("status pending", 32'h00000084, {24'h0, rd[15:8]});
    chk("status base", 32'h00000001, {31'h0, rd[20]});
    chk("status flag", 32'h00000000, {31'h0, rd[19]});
    kick(8'h00, 8'h00, 8'h80);
    chk("lowerGroupDisableN", 1'b1, lowerGroupDisableN);
    chk("unsolicited dropped", 1'b1, unsolicitedRequestOutN);
    addrStatReq(8'hfb, 3'h5);
    doOp(psiu_pkg::OP_DEV_WRITE, 3'h2, 1'b1);
    chk("solicited port3", 1'b0, solicitedRequestOutN);
    chk("general port3", 1'b1, generalRequestOutN);
    axiWrite(psiu_pkg::REG_CTRL_OFS, 32'h000000fb, psiu_pkg::RESP_OKAY);
    @(negedge clock);
    chk("masked request", 1'b1, solicitedRequestOutN);
    axiWrite(psiu_pkg::REG_CTRL_OFS, 32'h000000ff, psiu_pkg::RESP_OKAY);
    doOp(psiu_pkg::OP_DEV_READ, 3'h2, 1'b0);
    @(negedge clock);
    chk("solicited cleared", 1'b1, solicitedRequestOutN);
    kick(8'h00, 8'h80, 8'h00);
    chk("general ready", 1'b0, generalRequestOutN);
    addrStatReq(8'h7f, 3'h0);
    kick(8'h00, 8'h00, 8'h80);
    chk("general idle", 1'b1, generalRequestOutN);
    wrapUp();
  end
endmodule : psiu_top_tb
`default_nettype wire
